// File: shared/timer_input_capture_cfg.svh
// register offsets, field positions and reset values of the capture timer
`ifndef TIMER_INPUT_CAPTURE_CFG_SVH
`define TIMER_INPUT_CAPTURE_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL        12'h000
`define OFS_COUNT_HIGH     12'h004
`define OFS_COUNT_LOW      12'h008
`define OFS_RELOAD_HIGH    12'h00c
`define OFS_RELOAD_LOW     12'h010
`define OFS_CAPTURE_HIGH   12'h014
`define OFS_CAPTURE_LOW    12'h018
`define OFS_STATUS         12'h01c
`define OFS_MASK           12'h020
`define OFS_ALT_FUNC       12'h024

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTL_ENABLE_BIT     7
`define CTL_POLARITY_BIT   6
`define CTL_PRESCALE_HI    5
`define CTL_PRESCALE_LO    3
`define CTL_OUT_MODE_BIT   2
`define CTL_SOURCE_HI      1
`define CTL_SOURCE_LO      0

// status and mask bits
`define STAT_CAPTURE_BIT   0
`define STAT_RELOAD_BIT    1

// alternate function enable bits
`define ALT_PIN_ZERO_BIT   0
`define ALT_PIN_ONE_BIT    1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CONTROL        8'h00
`define RST_COUNT          16'h0001
`define RST_RELOAD         16'hffff
`define RST_CAPTURE        16'h0000
`define RST_MASK           2'h0
`define RST_ALT_FUNC       2'h0
`define RESTART_COUNT      16'h0001
`define SYNC_STAGES        3

`endif

// File: shared/timer_input_capture_pkg.sv
// types shared by the capture timer design and its bench
package timer_input_capture_pkg;

    typedef logic [15:0] word16_t;
    typedef logic [7:0]  byte_t;
    typedef logic [31:0] apb_data_t;
    typedef logic [11:0] apb_addr_t;

    // interrupt source selection codes
    typedef enum logic [1:0] {
        src_both    = 2'h0,
        src_capture = 2'h1,
        src_reload  = 2'h2,
        src_none    = 2'h3
    } interrupt_source_select_t;

endpackage : timer_input_capture_pkg

// File: verilog/timer_input_capture.sv
// capture timer: apb registers, counter, input capture, pins and interrupt
`include "timer_input_capture_cfg.svh"

// Summary of operation
// - capture edge selectable rising or falling
// - counter loadable by software, typically 0001h
// - reload value held in high/low pair
// - capture registers written by capture or by software
// - interrupt on capture and reload once unmasked; mask resets to 0
// - source field limits interrupt to one event or none
// - enable write starts counting immediately
// - count advances once per prescale clocks
// - port a alternate function selected directly
// - pin zero is input or inverted output
// - timer uses pin zero and pin one
module timer_input_capture
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire timer_input_capture_pkg::apb_addr_t paddr,
    input  wire timer_input_capture_pkg::apb_data_t pwdata,
    output logic                                   pready,
    output timer_input_capture_pkg::apb_data_t     prdata,
    output logic                                   pslverr,
    output logic                                   irq,
    input  wire logic                              port_a_bit_zero_in,
    output logic                                   port_a_bit_zero_out,
    output logic                                   port_a_bit_zero_oe,
    output logic                                   port_a_bit_one_out,
    output logic                                   port_a_bit_one_oe
);
    import timer_input_capture_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    byte_t                    timer_control_first;
    word16_t                  count;
    word16_t                  reload;
    word16_t                  capture;
    logic [1:0]               status;
    logic [1:0]               mask;
    logic [1:0]               alt_func;
    logic [7:0]               prescale_count;
    logic [2:0]               sync;
    logic                     pin_level;
    logic                     timer_out;
    logic                     enable_prev;
    logic                     access_done;
    logic                     wr_done;
    logic                     rd_done;
    logic                     enabled;
    logic                     out_mode;
    logic                     tick;
    logic                     edge_seen;
    logic                     capture_event;
    logic                     reload_event;
    logic                     start_pulse;
    logic [1:0]               next_status;
    logic [1:0]               event_vec;
    logic [7:0]               prescale_limit;
    interrupt_source_select_t interrupt_source_select;

    // decode an offset into a mapped flag
    function automatic logic is_mapped(input apb_addr_t a);
        is_mapped = (a == `OFS_CONTROL) || (a == `OFS_COUNT_HIGH)
                 || (a == `OFS_COUNT_LOW) || (a == `OFS_RELOAD_HIGH)
                 || (a == `OFS_RELOAD_LOW) || (a == `OFS_CAPTURE_HIGH)
                 || (a == `OFS_CAPTURE_LOW) || (a == `OFS_STATUS)
                 || (a == `OFS_MASK) || (a == `OFS_ALT_FUNC);
    endfunction : is_mapped

    // write strobe for one offset, used by every register except status
    function automatic logic wr_hit(input logic done, input apb_addr_t a,
                                    input apb_addr_t ofs);
        wr_hit = done && (a == ofs);
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // one wait state: ready rises in the second access cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pready <= 1'b0;
        else
            pready <= psel && penable && !pready;
    end

    assign access_done = psel && penable && pready;
    assign wr_done     = access_done && pwrite;
    assign rd_done     = access_done && !pwrite;

    // error answer for unmapped offsets, set alongside ready
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pslverr <= 1'b0;
        else
            pslverr <= psel && penable && !pready && !is_mapped(paddr);
    end

    // read data mux, captured while ready is raised
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && penable && !pready && !pwrite)
        begin
            unique case (paddr)
                `OFS_CONTROL:      prdata <= {24'h00_0000, timer_control_first};
                `OFS_COUNT_HIGH:   prdata <= {24'h00_0000, count[15:8]};
                `OFS_COUNT_LOW:    prdata <= {24'h00_0000, count[7:0]};
                `OFS_RELOAD_HIGH:  prdata <= {24'h00_0000, reload[15:8]};
                `OFS_RELOAD_LOW:   prdata <= {24'h00_0000, reload[7:0]};
                `OFS_CAPTURE_HIGH: prdata <= {24'h00_0000, capture[15:8]};
                `OFS_CAPTURE_LOW:  prdata <= {24'h00_0000, capture[7:0]};
                `OFS_STATUS:       prdata <= {30'h0000_0000, status};
                `OFS_MASK:         prdata <= {30'h0000_0000, mask};
                `OFS_ALT_FUNC:     prdata <= {30'h0000_0000, alt_func};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // control written whole; software disables first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            timer_control_first <= `RST_CONTROL;
        else if (wr_hit(wr_done, paddr, `OFS_CONTROL))
            timer_control_first <= pwdata[7:0];
    end

    assign enabled                 = timer_control_first[`CTL_ENABLE_BIT];
    assign out_mode                = timer_control_first[`CTL_OUT_MODE_BIT];
    assign interrupt_source_select = interrupt_source_select_t'(
        timer_control_first[`CTL_SOURCE_HI:`CTL_SOURCE_LO]);
    assign prescale_limit          = 8'h01 << timer_control_first[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];

    // reload value as a high/low byte pair
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reload <= `RST_RELOAD;
        else if (wr_hit(wr_done, paddr, `OFS_RELOAD_HIGH))
            reload[15:8] <= pwdata[7:0];
        else if (wr_hit(wr_done, paddr, `OFS_RELOAD_LOW))
            reload[7:0] <= pwdata[7:0];
    end

    // interrupt mask and alternate function enables
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mask     <= `RST_MASK;
            alt_func <= `RST_ALT_FUNC;
        end
        else
        begin
            if (wr_hit(wr_done, paddr, `OFS_MASK))
                mask <= pwdata[1:0];
            if (wr_hit(wr_done, paddr, `OFS_ALT_FUNC))
                alt_func <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // timer input synchroniser and edge detect
    // ------------------------------------------------------------------
    // three stages; level accepted once stages two and three agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync      <= 3'h0;
            pin_level <= 1'b0;
        end
        else
        begin
            sync <= {sync[1:0], port_a_bit_zero_in};
            if (sync[1] == sync[2])
                pin_level <= sync[2];
        end
    end

    // polarity bit picks rising or falling edge
    assign edge_seen = (sync[1] == sync[2]) && (sync[2] != pin_level)
                    && (sync[2] == !timer_control_first[`CTL_POLARITY_BIT]);

    // pin zero is an input only outside output mode
    // alternate function enable routes the pin directly
    assign capture_event = enabled && !out_mode && alt_func[`ALT_PIN_ZERO_BIT]
                        && edge_seen;

    // ------------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------------
    // rising enable restarts the prescaler at once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            enable_prev <= 1'b0;
        else
            enable_prev <= enabled;
    end

    assign start_pulse = enabled && !enable_prev;

    // one count tick per prescale clock cycles
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prescale_count <= 8'h00;
        else if (!enabled || start_pulse || tick)
            prescale_count <= 8'h00;
        else
            prescale_count <= prescale_count + 8'h01;
    end

    assign tick         = enabled && !start_pulse
                       && (prescale_count == prescale_limit - 8'h01);
    // reload when count matches without a capture
    assign reload_event = tick && (count == reload) && !capture_event;

    // software load; restart at 0001h on reload
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count <= `RST_COUNT;
        else if (wr_hit(wr_done, paddr, `OFS_COUNT_HIGH))
            count[15:8] <= pwdata[7:0];
        else if (wr_hit(wr_done, paddr, `OFS_COUNT_LOW))
            count[7:0] <= pwdata[7:0];
        else if (reload_event)
            count <= `RESTART_COUNT;
        else if (tick)
            count <= count + 16'h0001;
    end

    // active edge copies count; software may clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            capture <= `RST_CAPTURE;
        else if (capture_event)
            capture <= count;
        else if (wr_hit(wr_done, paddr, `OFS_CAPTURE_HIGH))
            capture[15:8] <= pwdata[7:0];
        else if (wr_hit(wr_done, paddr, `OFS_CAPTURE_LOW))
            capture[7:0] <= pwdata[7:0];
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    // both sources by default; source field limits them
    always_comb
    begin
        event_vec = 2'h0;
        unique case (interrupt_source_select)
            src_both:    event_vec = {reload_event, capture_event};
            src_capture: event_vec = {1'b0, capture_event};
            src_reload:  event_vec = {reload_event, 1'b0};
            src_none:    event_vec = 2'h0;
        endcase
    end

    // read of status clears it; a new event in that cycle wins
    always_comb
    begin
        next_status = status;
        if (rd_done && (paddr == `OFS_STATUS))
            next_status = 2'h0;
        next_status = next_status | event_vec;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            status <= 2'h0;
        else
            status <= next_status;
    end

    // level interrupt while any unmasked status bit is set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(next_status & mask);
    end

    // ------------------------------------------------------------------
    // timer output pins
    // ------------------------------------------------------------------
    // output toggles on each reload in output mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            timer_out <= 1'b0;
        else if (!enabled || !out_mode)
            timer_out <= 1'b0;
        else if (reload_event)
            timer_out <= !timer_out;
    end

    // pin zero inverted output, pin one true output
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_a_bit_zero_out <= 1'b0;
            port_a_bit_zero_oe  <= 1'b0;
            port_a_bit_one_out  <= 1'b0;
            port_a_bit_one_oe   <= 1'b0;
        end
        else
        begin
            port_a_bit_zero_out <= !timer_out;
            port_a_bit_zero_oe  <= alt_func[`ALT_PIN_ZERO_BIT] && out_mode;
            port_a_bit_one_out  <= timer_out;
            port_a_bit_one_oe   <= alt_func[`ALT_PIN_ONE_BIT];
        end
    end

endmodule : timer_input_capture

// File: tb/timer_input_capture_monitor.sv
// concurrent checks on the bus, interrupt and pin ports of the capture timer
module timer_input_capture_monitor
(
    input wire logic                               clk,
    input wire logic                               rst,
    input wire logic                               psel,
    input wire logic                               penable,
    input wire logic                               pwrite,
    input wire logic                               pready,
    input wire timer_input_capture_pkg::apb_data_t prdata,
    input wire logic                               pslverr,
    input wire logic                               irq,
    input wire logic                               port_a_bit_zero_out,
    input wire logic                               port_a_bit_zero_oe,
    input wire logic                               port_a_bit_one_out,
    input wire logic                               port_a_bit_one_oe
);
    import timer_input_capture_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    default clocking main_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // register bus timing
    // ----------------------------------------------------------------
    ready_one_wait_a: assert property
        (psel && penable && !pready |=> pready) else $error("no answer after one wait");
    ready_pulse_a: assert property
        (pready |=> !pready) else $error("ready held too long");
    ready_access_a: assert property
        (pready |-> psel && penable) else $error("ready outside access");
    err_with_ready_a: assert property
        (pslverr |-> pready) else $error("error without ready");
    err_zero_data_a: assert property
        (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read gave data");
    upper_zero_a: assert property
        (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");

    // ----------------------------------------------------------------
    // interrupt and pins
    // ----------------------------------------------------------------
    quiet_start_a: assert property
        ($fell(rst) |-> !irq && !pready) else $error("outputs busy after reset");
    irq_fall_access_a: assert property
        ($fell(irq) |-> $past(psel && penable && pready)) else $error("irq dropped alone");
    pins_inverse_a: assert property
        (port_a_bit_zero_oe && port_a_bit_one_oe |-> port_a_bit_zero_out != port_a_bit_one_out)
        else $error("pin outputs not inverse");
endmodule : timer_input_capture_monitor

bind timer_input_capture timer_input_capture_monitor u_timer_input_capture_monitor (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .port_a_bit_zero_out(port_a_bit_zero_out), .port_a_bit_zero_oe(port_a_bit_zero_oe),
    .port_a_bit_one_out(port_a_bit_one_out), .port_a_bit_one_oe(port_a_bit_one_oe));

// File: tb/signal_source.sv
// model of the external source that drives the timer input pin
module signal_source
(
    input  wire logic clk,
    input  wire logic level_req,
    input  wire logic slow,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt = 2'h0;
    initial pin = 1'b0;

    // follows the requested level at once, or three clocks late when slow
    always @(posedge clk)
    begin
        if (level_req == pin || !slow || wait_cnt == 2'h2)
        begin
            pin      <= level_req;
            wait_cnt <= 2'h0;
        end
        else
            wait_cnt <= wait_cnt + 2'h1;
    end
endmodule : signal_source

// File: tb/testbench.sv
// self-checking bench of the capture timer
`include "timer_input_capture_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_input_capture_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    apb_addr_t   paddr;
    apb_data_t   pwdata, prdata;
    logic        zo, zoe, oo, ooe, src_pin, pad, level_req, slow;
    int          fail_count, total_checks, seed;
    logic [32:0] exp_q[$];
    logic [32:0] got;
    byte_t       h;
    localparam byte_t rv[10] = '{8'h00, 8'h00, 8'h01, 8'hff, 8'hff,
                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // wire level of the two-way timer pin
    assign pad = zoe ? zo : src_pin;

    timer_input_capture u_timer_input_capture (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
        .port_a_bit_zero_in(pad), .port_a_bit_zero_out(zo), .port_a_bit_zero_oe(zoe),
        .port_a_bit_one_out(oo), .port_a_bit_one_oe(ooe));
    signal_source u_signal_source (.clk(clk), .level_req(level_req), .slow(slow),
        .pin(src_pin));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // one bus transfer; a read notes its expected answer
    task automatic xfer(input logic w, input apb_addr_t a, input byte_t d,
                        input logic [32:0] e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!w)
            exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            fail_count++;
            $display("ERROR %0t bus hang", $time);
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input apb_addr_t a, input byte_t d);
        xfer(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input apb_addr_t a, input byte_t d, input logic err = 1'b0);
        xfer(1'b0, a, d, {err, 24'h0, d});
    endtask : rd

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : cyc

    // compares each read answer with the oldest note
    always @(posedge clk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            got = exp_q.size() > 0 ? exp_q.pop_front() : 33'hx;
            `CHK({pslverr, prdata}, got)
        end

    initial
    begin
        seed = 32'h429cf5b9;
        {rst, psel, penable, pwrite, level_req, slow} = 6'b100000;
        paddr = 12'h0;
        pwdata = 32'h0;
        fail_count = 0;
        total_checks = 0;
        cyc(10);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++)
            rd(12'(i * 4), rv[i]);
        rd(12'h028, 8'h00, 1'b1);
        `CHK(zoe, 1'b0)
        wr(`OFS_ALT_FUNC, 8'h01);
        // capture on each edge sense, wrong edge first
        for (int p = 0; p < 2; p++)
        begin
            h = 8'($random(seed)) & 8'h7f;
            wr(`OFS_CONTROL, 8'(p * 64) | 8'h38);
            level_req <= !p[0];
            slow <= p[0];
            wr(`OFS_COUNT_HIGH, h);
            wr(`OFS_COUNT_LOW, 8'h10);
            wr(`OFS_CAPTURE_HIGH, 8'h00);
            wr(`OFS_CAPTURE_LOW, 8'h00);
            wr(`OFS_MASK, 8'(p + 1));
            wr(`OFS_CONTROL, 8'(p * 64) | 8'hb8);
            cyc(200);
            level_req <= p[0];
            cyc(224);
            level_req <= !p[0];
            cyc(10);
            `CHK(irq, 1'(p == 0))
            wr(`OFS_CONTROL, 8'(p * 64) | 8'h38);
            rd(`OFS_CAPTURE_HIGH, h);
            rd(`OFS_CAPTURE_LOW, 8'h13);
            rd(`OFS_COUNT_LOW, 8'h13);
            rd(`OFS_STATUS, 8'h01);
            rd(`OFS_STATUS, 8'h00);
        end
        cyc(2);
        `CHK(irq, 1'b0)
        // each interrupt source code with fast reloads
        for (int s = 0; s < 4; s++)
        begin
            wr(`OFS_CONTROL, 8'(s));
            level_req <= 1'b0;
            wr(`OFS_COUNT_HIGH, 8'h00);
            wr(`OFS_COUNT_LOW, 8'h01);
            wr(`OFS_RELOAD_HIGH, 8'h00);
            wr(`OFS_RELOAD_LOW, 8'h03);
            wr(`OFS_CAPTURE_LOW, 8'h00);
            wr(`OFS_MASK, 8'h03);
            wr(`OFS_CONTROL, 8'h80 | 8'(s));
            cyc(20);
            level_req <= (s != 2);
            cyc(10);
            `CHK(irq, 1'(s != 3))
            wr(`OFS_CONTROL, 8'(s));
            rd(`OFS_STATUS, {6'h0, 1'(s == 0 || s == 2), 1'(s < 2)});
            if (s == 2)
                rd(`OFS_CAPTURE_LOW, 8'h00);
        end
        // output mode on both pins
        wr(`OFS_ALT_FUNC, 8'h03);
        wr(`OFS_CONTROL, 8'h84);
        cyc(5);
        `CHK({zoe, ooe}, 2'b11)
        `CHK(zo, ~oo)
        report_and_stop();
    end
endmodule : testbench
